// ==== include/cmb_pkg.sv ====
// Shared constants and types of the CAN message buffer manager
`default_nettype none
package cmb_pkg;
    localparam int NTX       = 3;
    localparam int RX_DEPTH  = 5;
    localparam int MSG_BYTES = 15;
    localparam int MSG_WORDS = 4;
    localparam int LOCAL_TX_PRIORITY_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int TS_W      = 16;

    localparam logic [7:0] TXE_OFF      = 8'h00;
    localparam logic [7:0] ABT_REQ_OFF  = 8'h04;
    localparam logic [7:0] ABT_ACK_OFF  = 8'h08;
    localparam logic [7:0] TX_IE_OFF    = 8'h0C;
    localparam logic [7:0] RXFLG_OFF    = 8'h10;
    localparam logic [7:0] RX_IE_OFF    = 8'h14;
    localparam logic [7:0] ACC_ID_OFF   = 8'h18;
    localparam logic [7:0] ACC_MASK_OFF = 8'h1C;
    localparam logic [7:0] CTRL_OFF     = 8'h20;
    localparam logic [2:0] TXB_FIRST    = 3'h2;
    localparam logic [2:0] LOCAL_TX_PRIORITY_WORD    = 3'h4;
    localparam logic [3:0] FOREGROUND_RX_BUFFER_PAGE    = 4'hC;

    localparam int RXF_BIT   = 0;
    localparam int TS_EN_BIT = 0;

    localparam logic [31:0] ACC_ID_RST   = 32'h0000_0000;
    localparam logic [31:0] ACC_MASK_RST = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [LOCAL_TX_PRIORITY_W-1:0] cmb_local_tx_priority_t;

    typedef struct packed {
        logic [MSG_WORDS-1:0][31:0] word;
    } cmb_msg_s;
endpackage
`default_nettype wire

// ==== sim/cmb_engine_model.sv ====
// Behavioural CAN protocol engine driving the buffer manager's far side
`default_nettype none
module cmb_engine_model (
    input  wire logic   clk,
    input  wire logic   tx_sel_valid,
    output logic        arb_start,
    output logic        tx_start,
    output logic        tx_done,
    output logic        tx_err,
    output logic        rx_wr,
    output logic [1:0]  rx_widx,
    output logic [31:0] rx_wdata,
    output logic        rx_end,
    output logic        rx_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {arb_start, tx_start, tx_done, tx_err, rx_wr, rx_end, rx_ok} = '0;
        rx_widx = '0;
        rx_wdata = '0;
    end
    task automatic arb();
        @(posedge clk) arb_start <= 1'b1;
        @(posedge clk) arb_start <= 1'b0;
        @(posedge clk);
    endtask
    // Only an offered buffer may be started
    task automatic start();
        @(posedge clk) tx_start <= tx_sel_valid;
        @(posedge clk) tx_start <= 1'b0;
    endtask
    // A frame on the wire is slow next to the register bus
    task automatic finish(input logic ok);
        repeat (4) @(posedge clk);
        tx_done <= ok;
        tx_err <= !ok;
        @(posedge clk);
        {tx_done, tx_err} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic frame(input logic [31:0] id, input logic ok);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rx_wr <= 1'b1;
            rx_widx <= 2'(i);
            rx_wdata <= (i == 0) ? id : 32'hA5A5_0000 + 32'(i);
        end
        @(posedge clk);
        {rx_wr, rx_end, rx_ok} <= {1'b0, 1'b1, ok};
        // Inverted so that a stale data word is never mistaken for a fresh one
        rx_wdata <= ~rx_wdata;
        @(posedge clk);
        {rx_end, rx_ok} <= 2'b00;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== sim/cmb_top_test.sv ====
// Directed self-checking bench for the CAN message buffer manager
`default_nettype none
module cmb_top_test import cmb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rx_widx, tx_sel_idx;
    logic [1:0] wresp;
    logic arb_start, tx_start, tx_done, tx_err, rx_wr, rx_end, rx_ok;
    logic [31:0] rx_wdata;
    logic tx_sel_valid, rx_ready, tx_irq, rx_irq;
    cmb_msg_s tx_frame;
    int checks = 0, mismatches = 0;

    always #5 clk = ~clk;

    cmb_top #(.NUM_TX(NTX), .FIFO_DEPTH(RX_DEPTH)) dut (
        .clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .arb_start(arb_start), .tx_start(tx_start),
        .tx_done(tx_done), .tx_err(tx_err), .tx_sel_valid(tx_sel_valid),
        .tx_sel_idx(tx_sel_idx), .tx_frame(tx_frame), .rx_wr(rx_wr), .rx_widx(rx_widx),
        .rx_wdata(rx_wdata), .rx_end(rx_end), .rx_ok(rx_ok), .rx_ready(rx_ready),
        .tx_irq(tx_irq), .rx_irq(rx_irq));

    cmb_engine_model eng (
        .clk(clk), .tx_sel_valid(tx_sel_valid), .arb_start(arb_start),
        .tx_start(tx_start), .tx_done(tx_done), .tx_err(tx_err), .rx_wr(rx_wr),
        .rx_widx(rx_widx), .rx_wdata(rx_wdata), .rx_end(rx_end), .rx_ok(rx_ok));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        while (!s_axi_bvalid) @(posedge clk);
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs well under two thousand cycles
    initial begin
        #200us;
        mismatches++;
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] t;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(TXE_OFF, 32'h0000_0007);
        rchk(ABT_ACK_OFF, 32'h0000_0000);
        rchk(RXFLG_OFF, 32'h0000_0000);
        rd(8'h30, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h30, 32'h0000_0000);
        chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
        for (int n = 0; n < 3; n++) begin
            wr(8'h40 + 8'(32 * n), 32'h0000_0A00 + 32'(n));
            wr(8'h50 + 8'(32 * n), (n == 0) ? 32'h0000_001E : 32'h0000_000A);
        end
        wr(TXE_OFF, 32'h0000_0007);
        chk({30'h0, wresp}, {30'h0, RESP_OKAY});
        eng.arb();
        chk({30'h0, tx_sel_idx}, 32'h0000_0001);
        chk({31'h0, tx_sel_valid}, 32'h0000_0001);
        chk(tx_frame.word[0], 32'h0000_0A01);
        eng.start();
        eng.finish(1'b0);
        eng.arb();
        chk({30'h0, tx_sel_idx}, 32'h0000_0001);
        eng.start();
        eng.finish(1'b1);
        rchk(TXE_OFF, 32'h0000_0002);
        rchk(ABT_ACK_OFF, 32'h0000_0000);
        chk({31'h0, tx_irq}, 32'h0000_0000);
        wr(TX_IE_OFF, 32'h0000_0007);
        chk({31'h0, tx_irq}, 32'h0000_0001);
        $display("transmit scheduling test finished");
        eng.arb();
        chk({30'h0, tx_sel_idx}, 32'h0000_0002);
        eng.start();
        // Mask the already empty buffer so only the grant can raise the interrupt
        wr(TX_IE_OFF, 32'h0000_0005);
        chk({31'h0, tx_irq}, 32'h0000_0000);
        wr(ABT_REQ_OFF, 32'h0000_0005);
        rchk(ABT_ACK_OFF, 32'h0000_0001);
        rchk(TXE_OFF, 32'h0000_0003);
        chk({31'h0, tx_irq}, 32'h0000_0001);
        eng.finish(1'b1);
        chk({31'h0, tx_sel_valid}, 32'h0000_0000);
        rchk(TXE_OFF, 32'h0000_0007);
        rchk(ABT_ACK_OFF, 32'h0000_0001);
        $display("abort test finished");
        wr(ACC_MASK_OFF, 32'hFFFF_FF00);
        wr(ACC_ID_OFF, 32'h0000_0100);
        wr(CTRL_OFF, 32'h0000_0001);
        eng.frame(32'h0000_0200, 1'b1);
        eng.frame(32'h0000_0100, 1'b0);
        rchk(RXFLG_OFF, 32'h0000_0000);
        for (int i = 0; i < 6; i++) eng.frame(32'h0000_0100 + 32'(i), 1'b1);
        chk({31'h0, rx_ready}, 32'h0000_0000);
        rchk(RXFLG_OFF, 32'h0000_0001);
        wr(RX_IE_OFF, 32'h0000_0001);
        chk({31'h0, rx_irq}, 32'h0000_0001);
        // Back-to-back frames end seven cycles apart, so stamps step by seven
        for (int i = 0; i < 5; i++) begin
            rchk(8'hC0, 32'h0000_0100 + 32'(i));
            rd(8'hCC, d, r);
            chk(d & 32'hFFFF_0000, 32'hA5A5_0000);
            if (i > 0) chk({16'h0, d[15:0] - t}, 32'h0000_0007);
            t = d[15:0];
            wr(RXFLG_OFF, 32'h0000_0001);
        end
        rchk(RXFLG_OFF, 32'h0000_0000);
        chk({31'h0, rx_irq}, 32'h0000_0000);
        $display("receive fifo test finished");
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== verilog/cmb_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module cmb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("cmb_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [CW-1:0]    cnt_r;

    wire push = ce & in_valid & in_ready;
    wire pop  = ce & out_valid & out_ready;

    assign in_ready  = (cnt_r != FULL);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/cmb_top.sv ====
// CAN message buffer manager: transmit scheduling, abort and receive FIFO
// Overview of operation
// - Successful transmission sets that buffer's empty flag again.
// - A set empty flag raises the transmit interrupt only if unmasked.
// - Among pending buffers at arbitration, pick by local priority.
// - Eight-bit priority per buffer; smallest value is most urgent.
// - Selection repeats on every arbitration, also after a transmit error.
// - A buffer already on the bus is never aborted.
// - Abort grant sets acknowledge, sets empty flag, then transmit interrupt.
// - On release, acknowledge reads 1 if withdrawn, 0 if sent.
// - Received messages go into a five-deep receive FIFO.
// - Background buffer is internal; CPU sees only the foreground window.
// - Each receive buffer holds 15 bytes including optional time stamp.
// - Receive full flag marks a valid, filter-matched foreground message.
// - Incoming frame is written to background while filter is evaluated.
// - Valid, filter-matched frame moves into the FIFO if it is not full and sets the receive full flag.
`default_nettype none
module cmb_top import cmb_pkg::*; #(
    parameter int NUM_TX     = NTX,
    parameter int FIFO_DEPTH = RX_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              arb_start,
    input  wire logic              tx_start,
    input  wire logic              tx_done,
    input  wire logic              tx_err,
    output logic                   tx_sel_valid,
    output logic [1:0]             tx_sel_idx,
    output cmb_msg_s               tx_frame,
    input  wire logic              rx_wr,
    input  wire logic [1:0]        rx_widx,
    input  wire logic [31:0]       rx_wdata,
    input  wire logic              rx_end,
    input  wire logic              rx_ok,
    output logic                   rx_ready,
    output logic                   tx_irq,
    output logic                   rx_irq
);
    if (NUM_TX < 1 || NUM_TX > 3 || FIFO_DEPTH < 2) begin : g_chk
        $error("cmb_top needs NUM_TX in 1..3 and FIFO_DEPTH >= 2");
    end

    logic [NUM_TX-1:0] txe_r;
    logic [NUM_TX-1:0] abort_req_r;
    logic [NUM_TX-1:0] abort_ack_r;
    logic [NUM_TX-1:0] tx_ie_r;
    logic              rx_ie_r;
    logic              ts_en_r;
    logic [31:0]       acc_id_r;
    logic [31:0]       acc_mask_r;
    logic [31:0]       tx_mem_r [NUM_TX][MSG_WORDS];
    cmb_local_tx_priority_t         local_tx_priority_r [NUM_TX];
    logic [1:0]        sel_r;
    logic              sel_v_r;
    logic              busy_r;
    cmb_msg_s          bg_r;
    logic              match_r;
    logic [TS_W-1:0]   ts_r;
    logic              bvalid_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic [1:0]        bresp_r;

    // Write side: address and data are taken together in one cycle
    wire       wr_en   = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    wire [7:0] waddr   = s_axi_awaddr;
    wire [2:0] wbuf    = waddr[7:5] - TXB_FIRST;
    wire [2:0] wword   = waddr[4:2];
    wire       w_txb   = (wbuf < 3'(NUM_TX)) && (wword <= LOCAL_TX_PRIORITY_WORD);
    wire       w_txe   = wr_en & (waddr == TXE_OFF);
    wire       w_areq  = wr_en & (waddr == ABT_REQ_OFF);
    wire       w_txie  = wr_en & (waddr == TX_IE_OFF);
    wire       w_rxflg = wr_en & (waddr == RXFLG_OFF);
    wire       w_rxie  = wr_en & (waddr == RX_IE_OFF);
    wire       w_accid = wr_en & (waddr == ACC_ID_OFF);
    wire       w_accmk = wr_en & (waddr == ACC_MASK_OFF);
    wire       w_ctrl  = wr_en & (waddr == CTRL_OFF);
    wire       w_mapped = w_txb | (waddr == TXE_OFF) | (waddr == ABT_REQ_OFF)
                        | (waddr == ABT_ACK_OFF) | (waddr == TX_IE_OFF)
                        | (waddr == RXFLG_OFF) | (waddr == RX_IE_OFF)
                        | (waddr == ACC_ID_OFF) | (waddr == ACC_MASK_OFF)
                        | (waddr == CTRL_OFF);
    wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    assign s_axi_awready = wr_en;
    assign s_axi_wready  = wr_en;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_en) begin
                bvalid_r <= 1'b1;
                bresp_r  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Transmit selection; strict less-than keeps the lower index on a tie
    logic [1:0] best_idx;
    logic       best_v;
    cmb_local_tx_priority_t  best_p;
    always_comb begin
        best_idx = 2'h0;
        best_v   = 1'b0;
        best_p   = '1;
        for (int i = 0; i < NUM_TX; i++) begin
            if (!txe_r[i] && (!best_v || local_tx_priority_r[i] < best_p)) begin
                best_idx = 2'(i);
                best_p   = local_tx_priority_r[i];
                best_v   = 1'b1;
            end
        end
    end

    wire [NUM_TX-1:0] grant_w;
    wire [NUM_TX-1:0] done_w;
    wire [NUM_TX-1:0] txe_nxt;
    wire [NUM_TX-1:0] ack_nxt;
    wire [NUM_TX-1:0] req_nxt;

    for (genvar i = 0; i < NUM_TX; i++) begin : g_tx
        wire on_bus  = busy_r & (sel_r == 2'(i));
        wire handed  = w_txe & s_axi_wstrb[0] & s_axi_wdata[i];
        wire w_here  = wr_en & w_txb & (wbuf == 3'(i)) & txe_r[i];
        assign grant_w[i] = abort_req_r[i] & ~txe_r[i] & ~on_bus;
        assign done_w[i]  = tx_done & on_bus;
        // Hardware release wins over a software hand-over in the same cycle
        assign txe_nxt[i] = (done_w[i] | grant_w[i]) | (txe_r[i] & ~handed);
        assign ack_nxt[i] = grant_w[i] | (abort_ack_r[i] & ~done_w[i] & ~handed);
        assign req_nxt[i] = (abort_req_r[i]
                           | (w_areq & s_axi_wstrb[0] & s_axi_wdata[i]))
                           & ~txe_nxt[i];

        // Buffers are writable only while software owns them
        always_ff @(posedge clk) begin
            if (rst) begin
                local_tx_priority_r[i] <= '0;
            end else if (ce && w_here) begin
                if (wword == LOCAL_TX_PRIORITY_WORD) begin
                    if (s_axi_wstrb[0]) begin
                        local_tx_priority_r[i] <= s_axi_wdata[LOCAL_TX_PRIORITY_W-1:0];
                    end
                end else begin
                    tx_mem_r[i][wword[1:0]] <= (tx_mem_r[i][wword[1:0]] & ~wmask)
                                             | (s_axi_wdata & wmask);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txe_r       <= '1;
            abort_ack_r <= '0;
            abort_req_r <= '0;
        end else if (ce) begin
            txe_r       <= txe_nxt;
            abort_ack_r <= ack_nxt;
            abort_req_r <= req_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_r   <= 2'h0;
            sel_v_r <= 1'b0;
            busy_r  <= 1'b0;
        end else if (ce) begin
            if (arb_start && !busy_r) begin
                sel_r   <= best_idx;
                sel_v_r <= best_v;
            end
            if (tx_start && tx_sel_valid) begin
                busy_r <= 1'b1;
            end else if (tx_done || tx_err) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_frame <= '0;
        end else if (ce && arb_start && !busy_r && best_v) begin
            for (int w = 0; w < MSG_WORDS; w++) begin
                tx_frame.word[w] <= tx_mem_r[best_idx][w];
            end
        end
    end

    // An aborted but not yet started buffer drops out of the offer at once
    assign tx_sel_valid = sel_v_r & ~txe_r[sel_r];
    assign tx_sel_idx   = sel_r;
    assign tx_irq       = |(txe_r & tx_ie_r & ~abort_req_r);

    // Receive path
    wire       rx_full;
    wire       fifo_in_ready;
    cmb_msg_s  fg_msg;
    cmb_msg_s  push_msg;
    wire       push_ok = rx_end & rx_ok & match_r;
    wire       push    = ce & push_ok & fifo_in_ready;
    wire       pop     = w_rxflg & s_axi_wstrb[0] & s_axi_wdata[RXF_BIT];

    always_comb begin
        push_msg = bg_r;
        if (ts_en_r) begin
            push_msg.word[MSG_WORDS-1][TS_W-1:0] = ts_r;
        end
    end

    cmb_fifo #(
        .WIDTH ($bits(cmb_msg_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (push_ok),
        .in_ready  (fifo_in_ready),
        .in_data   (push_msg),
        .out_valid (rx_full),
        .out_ready (pop),
        .out_data  (fg_msg)
    );

    assign rx_ready = fifo_in_ready;
    assign rx_irq   = rx_full & rx_ie_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            bg_r    <= '0;
            match_r <= 1'b0;
            ts_r    <= '0;
        end else if (ce) begin
            ts_r <= ts_r + 1'b1;
            if (rx_wr) begin
                bg_r.word[rx_widx] <= rx_wdata;
                if (rx_widx == 2'h0) begin
                    match_r <= ((rx_wdata ^ acc_id_r) & acc_mask_r) == 32'h0;
                end
            end
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ie_r    <= '0;
            rx_ie_r    <= 1'b0;
            ts_en_r    <= 1'b0;
            acc_id_r   <= ACC_ID_RST;
            acc_mask_r <= ACC_MASK_RST;
        end else if (ce) begin
            if (w_txie && s_axi_wstrb[0]) begin
                tx_ie_r <= s_axi_wdata[NUM_TX-1:0];
            end
            if (w_rxie && s_axi_wstrb[0]) begin
                rx_ie_r <= s_axi_wdata[0];
            end
            if (w_ctrl && s_axi_wstrb[0]) begin
                ts_en_r <= s_axi_wdata[TS_EN_BIT];
            end
            if (w_accid) begin
                acc_id_r <= (acc_id_r & ~wmask) | (s_axi_wdata & wmask);
            end
            if (w_accmk) begin
                acc_mask_r <= (acc_mask_r & ~wmask) | (s_axi_wdata & wmask);
            end
        end
    end

    // Read side
    wire       rd_en = ce & s_axi_arvalid & ~rvalid_r;
    wire [7:0] raddr = s_axi_araddr;
    wire [2:0] rbuf  = raddr[7:5] - TXB_FIRST;
    wire [2:0] rword = raddr[4:2];
    wire       r_txb = (rbuf < 3'(NUM_TX)) && (rword <= LOCAL_TX_PRIORITY_WORD);
    wire       r_fg  = (raddr[7:4] == FOREGROUND_RX_BUFFER_PAGE);
    wire [31:0] r_txb_d = (rword == LOCAL_TX_PRIORITY_WORD) ? 32'(local_tx_priority_r[rbuf[1:0]])
                                               : tx_mem_r[rbuf[1:0]][rword[1:0]];
    wire [31:0] r_fg_d  = rx_full ? fg_msg.word[raddr[3:2]] : 32'h0;
    wire        r_hit   = r_txb | r_fg | (raddr == TXE_OFF) | (raddr == ABT_REQ_OFF)
                        | (raddr == ABT_ACK_OFF) | (raddr == TX_IE_OFF)
                        | (raddr == RXFLG_OFF) | (raddr == RX_IE_OFF)
                        | (raddr == ACC_ID_OFF) | (raddr == ACC_MASK_OFF)
                        | (raddr == CTRL_OFF);
    wire [31:0] r_data  = r_txb                  ? r_txb_d
                        : r_fg                   ? r_fg_d
                        : (raddr == TXE_OFF)     ? 32'(txe_r)
                        : (raddr == ABT_REQ_OFF) ? 32'(abort_req_r)
                        : (raddr == ABT_ACK_OFF) ? 32'(abort_ack_r)
                        : (raddr == TX_IE_OFF)   ? 32'(tx_ie_r)
                        : (raddr == RXFLG_OFF)   ? 32'(rx_full)
                        : (raddr == RX_IE_OFF)   ? 32'(rx_ie_r)
                        : (raddr == ACC_ID_OFF)  ? acc_id_r
                        : (raddr == ACC_MASK_OFF) ? acc_mask_r
                        : (raddr == CTRL_OFF)    ? 32'(ts_en_r)
                        : 32'h0;

    assign s_axi_arready = rd_en;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= RESP_OKAY;
        end else if (ce) begin
            if (rd_en) begin
                rvalid_r <= 1'b1;
                rdata_r  <= r_data;
                rresp_r  <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic min_ok;
    always_comb begin
        min_ok = 1'b1;
        for (int i = 0; i < NUM_TX; i++) begin
            if (!txe_r[i] && local_tx_priority_r[i] < local_tx_priority_r[best_idx]) begin
                min_ok = 1'b0;
            end
            if (!txe_r[i] && local_tx_priority_r[i] == local_tx_priority_r[best_idx] && 2'(i) < best_idx) begin
                min_ok = 1'b0;
            end
        end
    end

    done_sets_empty_a: assert property (
        (ce && tx_done && busy_r) |=> txe_r[$past(sel_r)])
        else $error("sent buffer not released");
    done_irq_a: assert property (
        (ce && tx_done && busy_r && tx_ie_r[sel_r]) |=> tx_irq)
        else $error("unmasked release gave no interrupt");
    arb_picks_a: assert property (
        (ce && arb_start && !busy_r && best_v && !grant_w[best_idx])
        |=> sel_v_r && !txe_r[sel_r])
        else $error("arbitration selected no pending buffer");
    local_tx_priority_min_a: assert property (
        (ce && arb_start && best_v) |-> min_ok)
        else $error("selected buffer is not most urgent");
    err_rearb_a: assert property (
        (ce && tx_err && !tx_done) |=> !busy_r)
        else $error("error did not reopen arbitration");
    active_kept_a: assert property (
        (ce && busy_r && !tx_done && abort_req_r[sel_r]) |=> !abort_ack_r[$past(sel_r)])
        else $error("active buffer was aborted");
    abort_grant_a: assert property (
        (ce && |grant_w) |=> ((abort_ack_r & txe_r & $past(grant_w)) == $past(grant_w)))
        else $error("abort grant incomplete");
    sent_ack_zero_a: assert property (
        (ce && tx_done && busy_r) |=> !abort_ack_r[$past(sel_r)])
        else $error("sent buffer shows abort acknowledge");
    drop_bad_a: assert property (
        (ce && rx_end && !(rx_ok && match_r) && !pop) |=> rx_full == $past(rx_full))
        else $error("rejected frame changed receive state");
    push_full_a: assert property (
        push |=> rx_full)
        else $error("stored frame did not set full flag");
endmodule
`default_nettype wire
